//--- adc_aux_gain2_calibration.sv
`timescale 1ns/1ns
// Notes on behaviour
// - the offset trim in bits 14:0 is a signed twos complement value.
// - one offset trim count is a quarter of a result lsb.
// - offset 0x4000 is -4096 lsb, 0x3fff +4095.75, 0x7fff -0.25, 0x0001 +0.25.
// - offset trim zero leaves results unchanged and is the reset value.
// - the offset trim acts only on aux channel conversions taken at amplifier gain 2, never on tia or temperature.
// - the gain trim acts on all channels at gain 2 except tia and temperature.
// - the gain trim is 15 bits, bit 14 integer and bits 13:0 fraction.
// - gain trim code zero is illegal and forces a result of zero.
// - gain trim 0x4000 is unity and is the reset value.
// - the result is multiplied by gain code divided by 16384.
module adc_aux_gain2_calibration (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [15:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_raw_valid,
    input  wire logic [15:0] i_raw_sample,
    input  wire logic        i_pga_gain2,
    input  wire logic        i_chan_aux,
    input  wire logic        i_chan_tia_temp,
    output logic             o_result_valid,
    output logic      [15:0] o_adc_result_word
);
    logic        rst_meta;
    logic        rst_n_int;
    logic [31:0] prdata;
    logic [15:0] result_count;

    trim_if trims ();

    // reset release through two flops
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta  <= 1'b0;
            rst_n_int <= 1'b0;
        end else begin
            rst_meta  <= 1'b1;
            rst_n_int <= rst_meta;
        end
    end

    // apb decode
    wire        setup     = i_psel && !i_penable;
    wire        access    = i_psel && i_penable;
    wire [13:0] word_addr = i_paddr[15:2];
    wire        hit_gain  = word_addr == adc_cal_pkg::GAIN_TRIM_ADDR[15:2];
    wire        hit_ofs   = word_addr == adc_cal_pkg::OFS_TRIM_ADDR[15:2];
    wire        hit_stat  = word_addr == adc_cal_pkg::STATUS_ADDR[15:2];
    wire        mapped    = hit_gain || hit_ofs || hit_stat;
    wire        wr_ok     = access && i_pwrite;
    wire        wr_offset = wr_ok && hit_ofs;
    wire        wr_gain   = wr_ok && hit_gain;
    // only lanes 0 and 1 reach the 15-bit fields; upper bits are dropped
    wire [14:0] wmask     = {{7{i_pstrb[1]}}, {8{i_pstrb[0]}}};
    wire [14:0] wdata     = i_pwdata[14:0];
    wire        gain_bad  = trims.gain_trim == adc_cal_pkg::GAIN_ILLEGAL;
    wire [31:0] stat_word = {result_count, 15'h0000, gain_bad};
    wire [31:0] next_rd   = !setup || i_pwrite ? adc_cal_pkg::READ_IDLE :
                            hit_gain ? {17'h0_0000, trims.gain_trim} :
                            hit_ofs  ? {17'h0_0000, trims.offset_trim} :
                            hit_stat ? stat_word : adc_cal_pkg::READ_IDLE;

    assign o_pready  = 1'b1;
    assign o_pslverr = access && !mapped;
    assign o_prdata  = prdata;

    always_ff @(posedge i_clk_sys or negedge rst_n_int) begin
        if (!rst_n_int) begin
            prdata       <= adc_cal_pkg::READ_IDLE;
            result_count <= 16'h0000;
        end else begin
            if (setup || access) begin
                prdata <= next_rd;
            end
            if (o_result_valid) begin
                result_count <= result_count + 16'h0001;
            end
        end
    end

    trim_regs u_regs (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (rst_n_int),
        .i_wr_offset (wr_offset),
        .i_wr_gain   (wr_gain),
        .i_wdata     (wdata),
        .i_wmask     (wmask),
        .trims       (trims.regs)
    );

    cal_datapath u_dp (
        .i_clk_sys       (i_clk_sys),
        .i_rst_n         (rst_n_int),
        .i_raw_valid     (i_raw_valid),
        .i_raw_sample    (i_raw_sample),
        .i_pga_gain2     (i_pga_gain2),
        .i_chan_aux      (i_chan_aux),
        .i_chan_tia_temp (i_chan_tia_temp),
        .trims           (trims.dp),
        .o_valid         (o_result_valid),
        .o_result        (o_adc_result_word)
    );

    // conditions the checks below are built from
    wire        in_gain   = i_raw_valid && i_pga_gain2 && !i_chan_tia_temp;
    wire        in_aux    = in_gain && i_chan_aux;
    wire        gain_one  = trims.gain_trim == adc_cal_pkg::GAIN_TRIM_RST;
    wire        ofs_zero  = trims.offset_trim == adc_cal_pkg::OFS_TRIM_RST;
    wire [14:0] ofs_val   = trims.offset_trim;
    wire [14:0] gain_val  = trims.gain_trim;
    wire [31:0] dbl_prod  = i_raw_sample * 16'h7fff;
    // expected results for gain codes one step either side of unity
    wire [16:0] up_lsb    = {1'b0, i_raw_sample} + {15'h0000, i_raw_sample[15:14]};
    wire [15:0] up_sat    = up_lsb[16] ? adc_cal_pkg::RESULT_MAX : up_lsb[15:0];
    wire [15:0] dn_lsb    = i_raw_sample - {14'h0000, i_raw_sample[15:14]}
                            - {15'h0000, |i_raw_sample[13:0]};

    a_trims_reset_val: assert property (
        @(posedge i_clk_sys) $rose(rst_n_int) |->
            ofs_val == 15'h0000 && gain_val == 15'h4000)
        else $error("trims not at reset values after reset");

    a_latency_two: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        i_raw_valid |-> ##2 o_result_valid)
        else $error("result not two cycles after sample");

    a_gain_zero_result: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_gain && gain_val == 15'h0000 |-> ##2 o_adc_result_word == 16'h0000)
        else $error("illegal gain did not force zero");

    a_unity_no_change: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_aux && gain_one && ofs_zero |->
            ##2 o_adc_result_word == $past(i_raw_sample, 2))
        else $error("unity trims changed the result");

    a_other_gain_pass: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        i_raw_valid && !i_pga_gain2 |->
            ##2 o_adc_result_word == $past(i_raw_sample, 2))
        else $error("trim applied outside gain 2");

    a_tia_temp_pass: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        i_raw_valid && i_chan_tia_temp |->
            ##2 o_adc_result_word == $past(i_raw_sample, 2))
        else $error("trim applied to tia or temperature channel");

    a_offset_quarter: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_aux && gain_one && ofs_val == 15'h0004 && i_raw_sample != 16'hffff |->
            ##2 o_adc_result_word == $past(i_raw_sample, 2) + 16'h0001)
        else $error("four offset counts are not one lsb");

    a_offset_neg: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_aux && gain_one && ofs_val == 15'h7ffc && i_raw_sample != 16'h0000 |->
            ##2 o_adc_result_word == $past(i_raw_sample, 2) - 16'h0001)
        else $error("negative offset not applied as minus one lsb");

    a_offset_min: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_aux && gain_one && ofs_val == 15'h4000 && i_raw_sample < 16'h1000 |->
            ##2 o_adc_result_word == 16'h0000)
        else $error("most negative offset not minus 4096");

    a_gain_half: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_gain && !i_chan_aux && gain_val == 15'h2000 |->
            ##2 o_adc_result_word == {1'b0, $past(i_raw_sample[15:1], 2)})
        else $error("gain 0x2000 did not halve the result");

    a_gain_double: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_gain && !i_chan_aux && gain_val == 15'h7fff && !i_raw_sample[15] |->
            ##2 o_adc_result_word == $past(dbl_prod[29:14], 2))
        else $error("gain 0x7fff not code over 16384");

    a_reserved_zero: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        access && !i_pwrite && (hit_gain || hit_ofs) |-> o_prdata[31:15] == 17'h0_0000)
        else $error("reserved trim bits read non zero");

    a_unmapped_err: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        access && !mapped |-> o_pslverr && o_pready)
        else $error("unmapped access not flagged");

    a_ofs_plus_quarter: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_aux && gain_one && ofs_val == 15'h0001
        |-> ##2 o_adc_result_word == $past(i_raw_sample, 2))
        else $error("plus quarter offset moved the result");

    a_ofs_minus_quarter: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_aux && gain_one && ofs_val == 15'h7fff && i_raw_sample != 16'h0000
        |-> ##2 o_adc_result_word == $past(i_raw_sample, 2) - 16'h0001)
        else $error("minus quarter offset not one lsb down");

    a_ofs_max_pos: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_aux && gain_one && ofs_val == 15'h3fff && i_raw_sample <= 16'hf000
        |-> ##2 o_adc_result_word == $past(i_raw_sample, 2) + 16'h0fff)
        else $error("largest positive offset not 4095 lsb");

    a_ofs_min_mid: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_aux && gain_one && ofs_val == 15'h4000 && i_raw_sample >= 16'h1000
        |-> ##2 o_adc_result_word == $past(i_raw_sample, 2) - 16'h1000)
        else $error("most negative offset not minus 4096 lsb");

    a_gain_min_code: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_gain && gain_val == 15'h0001 && (ofs_zero || !i_chan_aux)
        |-> ##2 o_adc_result_word == {14'h0000, $past(i_raw_sample[15:14], 2)})
        else $error("gain 0x0001 not code over 16384");

    a_gain_step_up: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_gain && gain_val == 15'h4001 && (ofs_zero || !i_chan_aux)
        |-> ##2 o_adc_result_word == $past(up_sat, 2))
        else $error("gain 0x4001 not code over 16384");

    a_gain_step_down: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        in_gain && gain_val == 15'h3fff && (ofs_zero || !i_chan_aux)
        |-> ##2 o_adc_result_word == $past(dn_lsb, 2))
        else $error("gain 0x3fff not code over 16384");

    a_tia_gain_ignored: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        i_raw_valid && i_pga_gain2 && i_chan_tia_temp && gain_val == 15'h0000
        |-> ##2 o_adc_result_word == $past(i_raw_sample, 2))
        else $error("illegal gain applied to tia or temperature channel");

    a_no_sample_quiet: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        !i_raw_valid
        |-> ##2 !o_result_valid)
        else $error("result valid without a sample");

    a_reset_out_zero: assert property (
        @(posedge i_clk_sys)
        $rose(rst_n_int)
        |-> !o_result_valid && o_adc_result_word == 16'h0000)
        else $error("result outputs not zero after reset");

    a_ofs_write_lands: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        access && i_pwrite && hit_ofs && i_pstrb == 4'hf
        |=> ofs_val == $past(i_pwdata[14:0]))
        else $error("offset trim write not stored");

    a_gain_write_lands: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        access && i_pwrite && hit_gain && i_pstrb == 4'hf
        |=> gain_val == $past(i_pwdata[14:0]))
        else $error("gain trim write not stored");

    a_unmapped_no_write: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        access && i_pwrite && !mapped
        |=> $stable(ofs_val) && $stable(gain_val))
        else $error("unmapped write changed a trim");

    a_read_keeps_trims: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        access && !i_pwrite
        |=> $stable(ofs_val) && $stable(gain_val))
        else $error("read changed a trim");

    a_status_flag: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        access && !i_pwrite && hit_stat
        |-> o_prdata[0] == (gain_val == adc_cal_pkg::GAIN_ILLEGAL))
        else $error("illegal gain flag wrong in status");

    a_err_access_only: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        !access
        |-> !o_pslverr)
        else $error("error flagged outside access");

    a_count_step: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        o_result_valid
        |=> result_count == $past(result_count) + 16'h0001)
        else $error("result count did not step");

    a_rdata_idle: assert property (
        @(posedge i_clk_sys) disable iff (!rst_n_int)
        !i_psel
        |-> o_prdata == adc_cal_pkg::READ_IDLE)
        else $error("read data not idle between transfers");
endmodule : adc_aux_gain2_calibration

//--- adc_cal_pkg.sv
package adc_cal_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 16;
    localparam int          RAW_W           = 16;
    localparam int          TRIM_W          = 15;
    localparam int          SUM_W           = 20;
    localparam int          OFS_FRAC        = 2;
    localparam int          GAIN_FRAC       = 14;
    localparam int          PROD_W          = 36;
    localparam int          CNT_W           = 16;
    localparam int          CNT_LSB         = 16;
    localparam int          ILLEGAL_BIT     = 0;
    localparam int          STRB_W          = 4;
    localparam int          PIPE_DEPTH      = 2;
    localparam logic [15:0] GAIN_TRIM_ADDR  = 16'h2274;
    localparam logic [15:0] OFS_TRIM_ADDR   = 16'h22c8;
    localparam logic [15:0] STATUS_ADDR     = 16'h2300;
    localparam logic [14:0] GAIN_TRIM_RST   = 15'h4000;
    localparam logic [14:0] OFS_TRIM_RST    = 15'h0000;
    localparam logic [14:0] GAIN_ILLEGAL    = 15'h0000;
    localparam logic [15:0] RESULT_MAX      = 16'hffff;
    localparam logic [31:0] READ_IDLE       = 32'h0000_0000;
endpackage : adc_cal_pkg

//--- adc_src_model.sv
`timescale 1ns/1ns
module adc_src_model (
    input  wire logic        i_clk,
    output logic             o_raw_valid,
    output logic      [15:0] o_raw_sample,
    output logic             o_pga_gain2,
    output logic             o_chan_aux,
    output logic             o_chan_tia_temp
);
    initial begin
        o_raw_valid = 1'b0;
        o_raw_sample = 16'h0000;
        {o_pga_gain2, o_chan_aux, o_chan_tia_temp} = 3'b000;
    end

    // one sample per call, flags held as levels; data scrambled after the pulse
    task automatic send(input logic [15:0] s, input logic [2:0] f);
        @(posedge i_clk);
        o_raw_valid <= 1'b1;
        o_raw_sample <= s;
        {o_pga_gain2, o_chan_aux, o_chan_tia_temp} <= f;
        @(posedge i_clk);
        o_raw_valid <= 1'b0;
        o_raw_sample <= ~s;
    endtask : send
endmodule : adc_src_model

//--- cal_datapath.sv
`timescale 1ns/1ns
module cal_datapath (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_raw_valid,
    input  wire logic [15:0] i_raw_sample,
    input  wire logic        i_pga_gain2,
    input  wire logic        i_chan_aux,
    input  wire logic        i_chan_tia_temp,
    trim_if.dp               trims,
    output logic             o_valid,
    output logic      [15:0] o_result
);
    logic               s1_valid;
    logic signed [19:0] s1_sum;
    logic        [14:0] s1_gain;
    logic               s1_zero;

    // offset on aux inputs at gain 2, gain on all but tia/temp at gain 2
    wire               gain_en  = i_pga_gain2 && !i_chan_tia_temp;
    wire               ofs_en   = gain_en && i_chan_aux;
    wire signed [19:0] ofs_ext  = {{5{trims.offset_trim[14]}}, trims.offset_trim};
    wire signed [19:0] raw_q    = $signed({2'b00, i_raw_sample, 2'b00});
    wire signed [19:0] next_sum = raw_q + (ofs_en ? ofs_ext : 20'sh0_0000);
    wire        [14:0] next_gn  = gain_en ? trims.gain_trim : adc_cal_pkg::GAIN_TRIM_RST;
    wire               next_zr  = gain_en && (trims.gain_trim == adc_cal_pkg::GAIN_ILLEGAL);
    // product scaled by 2^-16: two offset and fourteen gain fraction bits
    wire signed [35:0] prod     = s1_sum * $signed({1'b0, s1_gain});
    wire signed [19:0] scaled   = prod[35:16];
    wire        [15:0] next_res = s1_zero ? 16'h0000 :
                                  scaled[19] ? 16'h0000 :
                                  (|scaled[18:16]) ? adc_cal_pkg::RESULT_MAX :
                                  scaled[15:0];

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_valid <= 1'b0;
            s1_sum   <= 20'sh0_0000;
            s1_gain  <= adc_cal_pkg::GAIN_TRIM_RST;
            s1_zero  <= 1'b0;
            o_valid  <= 1'b0;
            o_result <= 16'h0000;
        end else begin
            s1_valid <= i_raw_valid;
            s1_sum   <= next_sum;
            s1_gain  <= next_gn;
            s1_zero  <= next_zr;
            o_valid  <= s1_valid;
            o_result <= next_res;
        end
    end
endmodule : cal_datapath

//--- tb_adc_aux_gain2_calibration.sv
`timescale 1ns/1ns
module tb_adc_aux_gain2_calibration;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rvalid;
    logic [15:0] rsample;
    logic        gain2;
    logic        aux;
    logic        tia;
    logic        res_valid;
    logic [15:0] res;
    int          failures = 0;
    int          checked = 0;
    int          nres = 0;

    always #2 clk = ~clk;

    adc_src_model u_src (.i_clk(clk), .o_raw_valid(rvalid), .o_raw_sample(rsample),
        .o_pga_gain2(gain2), .o_chan_aux(aux), .o_chan_tia_temp(tia));

    adc_aux_gain2_calibration u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_raw_valid(rvalid), .i_raw_sample(rsample), .i_pga_gain2(gain2),
        .i_chan_aux(aux), .i_chan_tia_temp(tia), .o_result_valid(res_valid),
        .o_adc_result_word(res));

    task automatic complete_run;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // ready, read data and error taken at the edge that ends access
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50)
            failures++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [15:0] expect_cal(logic [15:0] raw, logic [14:0] g,
                                                logic [14:0] o, logic [2:0] f);
        longint s;
        longint p;
        s = longint'(raw) * 4;
        if (f == 3'b110)
            s += longint'($signed(o));
        p = (f[2] && !f[0]) ? s * longint'(g) : s * 16384;
        p = p >>> 16;
        return (p < 0) ? 16'h0000 : ((p > 65535) ? 16'hffff : p[15:0]);
    endfunction : expect_cal

    task automatic cal_case(input logic [14:0] g, input logic [14:0] o,
                            input logic [15:0] raw, input logic [2:0] f);
        logic [31:0] r;
        logic        e;
        int          n;
        n = 0;
        apb(adc_cal_pkg::GAIN_TRIM_ADDR, 1'b1, {17'h0_0000, g}, r, e);
        apb(adc_cal_pkg::OFS_TRIM_ADDR, 1'b1, {17'h0_0000, o}, r, e);
        u_src.send(raw, f);
        do @(negedge clk); while (res_valid !== 1'b1 && ++n < 8);
        check({31'h0000_0000, res_valid}, 32'h0000_0001);
        nres++;
        check({16'h0000, res}, {16'h0000, expect_cal(raw, g, o, f)});
    endtask : cal_case

    task automatic test_reset;
        logic [31:0] r;
        logic        e;
        apb(adc_cal_pkg::GAIN_TRIM_ADDR, 1'b0, 32'h0000_0000, r, e);
        check(r, 32'h0000_4000);
        apb(adc_cal_pkg::OFS_TRIM_ADDR, 1'b0, 32'h0000_0000, r, e);
        check(r, 32'h0000_0000);
    endtask : test_reset

    task automatic test_reserved;
        logic [31:0] r;
        logic        e;
        apb(adc_cal_pkg::OFS_TRIM_ADDR, 1'b1, 32'hffff_ffff, r, e);
        apb(16'h2400, 1'b1, 32'h0000_0000, r, e);
        check({31'h0000_0000, e}, 32'h0000_0001);
        apb(adc_cal_pkg::OFS_TRIM_ADDR, 1'b0, 32'h0000_0000, r, e);
        check(r, 32'h0000_7fff);
        apb(16'h2400, 1'b0, 32'h0000_0000, r, e);
        check({31'h0000_0000, e}, 32'h0000_0001);
        check(r, 32'h0000_0000);
    endtask : test_reserved

    task automatic test_stream;
        cal_case(15'h4000, 15'h0000, 16'h1234, 3'b110);
        cal_case(15'h4000, 15'h4000, 16'h5000, 3'b110);
        cal_case(15'h4000, 15'h3fff, 16'h0010, 3'b110);
        cal_case(15'h4000, 15'h7fff, 16'h0100, 3'b110);
        cal_case(15'h4000, 15'h0001, 16'h0100, 3'b110);
        cal_case(15'h4000, 15'h0004, 16'h0100, 3'b010);
        cal_case(15'h2000, 15'h0000, 16'h1000, 3'b110);
        cal_case(15'h7fff, 15'h0000, 16'h9000, 3'b110);
        cal_case(15'h0001, 15'h0000, 16'hffff, 3'b110);
        cal_case(15'h4001, 15'h0000, 16'hffff, 3'b110);
        cal_case(15'h3fff, 15'h0000, 16'hffff, 3'b110);
        cal_case(15'h2000, 15'h0000, 16'h1000, 3'b101);
        cal_case(15'h2000, 15'h0004, 16'h1000, 3'b100);
        cal_case(15'h4000, 15'h0004, 16'h0100, 3'b110);
        cal_case(15'h4000, 15'h7ffc, 16'h0100, 3'b110);
        cal_case(15'h4000, 15'h4000, 16'h0800, 3'b110);
        cal_case(15'h7fff, 15'h0000, 16'h1000, 3'b100);
    endtask : test_stream

    task automatic test_illegal;
        logic [31:0] r;
        logic        e;
        cal_case(15'h0000, 15'h0000, 16'h1234, 3'b110);
        cal_case(15'h0000, 15'h0004, 16'h1000, 3'b101);
        apb(adc_cal_pkg::STATUS_ADDR, 1'b0, 32'h0000_0000, r, e);
        check({31'h0000_0000, r[0]}, 32'h0000_0001);
        check({16'h0000, r[31:16]}, {16'h0000, nres[15:0]});
    endtask : test_illegal

    task automatic test_rerun_reset;
        logic [31:0] r;
        logic        e;
        apb(adc_cal_pkg::OFS_TRIM_ADDR, 1'b1, 32'h0000_1234, r, e);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset();
        apb(adc_cal_pkg::STATUS_ADDR, 1'b0, 32'h0000_0000, r, e);
        check(r, 32'h0000_0000);
    endtask : test_rerun_reset

    initial begin
        #40000;
        failures++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_reset();
        test_reserved();
        test_stream();
        test_illegal();
        test_rerun_reset();
        complete_run();
    end
endmodule : tb_adc_aux_gain2_calibration

//--- trim_if.sv
`timescale 1ns/1ns
interface trim_if;
    logic [14:0] offset_trim;
    logic [14:0] gain_trim;
    modport regs (output offset_trim, output gain_trim);
    modport dp   (input offset_trim, input gain_trim);
    modport mon  (input offset_trim, input gain_trim);
endinterface : trim_if

//--- trim_regs.sv
`timescale 1ns/1ns
module trim_regs (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_wr_offset,
    input  wire logic        i_wr_gain,
    input  wire logic [14:0] i_wdata,
    input  wire logic [14:0] i_wmask,
    trim_if.regs             trims
);
    logic [14:0] offset_trim;
    logic [14:0] gain_trim;
    wire  [14:0] next_offset = (offset_trim & ~i_wmask) | (i_wdata & i_wmask);
    wire  [14:0] next_gain   = (gain_trim & ~i_wmask) | (i_wdata & i_wmask);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            offset_trim <= adc_cal_pkg::OFS_TRIM_RST;
            gain_trim   <= adc_cal_pkg::GAIN_TRIM_RST;
        end else begin
            if (i_wr_offset) begin
                offset_trim <= next_offset;
            end
            if (i_wr_gain) begin
                gain_trim <= next_gain;
            end
        end
    end

    assign trims.offset_trim = offset_trim;
    assign trims.gain_trim   = gain_trim;
endmodule : trim_regs
